// >>> include/mrpc_pkg.sv
// Constants for the port 3 / port 4 media link configuration block
package mrpc_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_P3_LINK_CTRL  = 8'hCF;
    localparam logic [7:0] ADDR_P3_ROLE_SEL   = 8'hDF;
    localparam logic [7:0] ADDR_TEST_THREE    = 8'hEF;
    localparam logic [7:0] ADDR_CLK_PHASE     = 8'hFF;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int BIT_HALF_DUPLEX = 7;
    localparam int BIT_FLOW_CTRL   = 6;
    localparam int BIT_SPEED_10    = 5;
    localparam int BIT_MAC_ROLE    = 6;
    localparam int BIT_TX_INVERT   = 6;
    localparam int BIT_RX_INVERT   = 4;
    // ----------------------------------------------------------------
    // Reset and fixed reserved values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_P3_LINK_CTRL = 8'h00;
    localparam logic [7:0] RST_P3_ROLE_SEL  = 8'h00;
    localparam logic [7:0] RST_CLK_PHASE    = 8'h00;
    localparam logic [7:0] FIX_ROLE_RSVD    = 8'h2C;
    localparam logic [7:0] FIX_TEST_THREE   = 8'h32;
    localparam logic [7:0] RD_UNMAPPED      = 8'h00;
    // ----------------------------------------------------------------
    // Scheduler
    // ----------------------------------------------------------------
    localparam int          NUM_QUEUES   = 4;
    localparam int          WEIGHT_W     = 4;
    localparam logic [1:0]  TOP_QUEUE    = 2'h3;
    localparam logic [1:0]  LOW_LAST     = 2'h2;
endpackage

// >>> hdl/mrpc_port_config.sv
// Port 3 media link and port 4 reduced link configuration with queue scheduler
`timescale 1ns/10ps
// Behaviour
// RULE_01 - Port 3 duplex bit set gives half duplex; clear gives full duplex.
// RULE_02 - Port 3 flow-control bit set enables full-duplex pause; clear disables it.
// RULE_03 - Port 3 speed bit set selects 10 Mbps; clear selects 100 Mbps.
// RULE_04 - Role bit set makes port 3 act as MAC; clear as PHY.
// RULE_05 - Transmit invert bit clocks port 4 output data on reference falling edge.
// RULE_06 - Receive invert bit inverts the port 4 receive reference clock output.
// RULE_07 - Software sets two or four queues before per-priority ingress limiting; the block has no queue-count setting and always uses four queues.
// RULE_08 - Top queue gets its exact rate; lower queues share by weight ratio.
// RULE_09 - Reserved fields read fixed values; writes never alter them.
module mrpc_port_config (
    input  wire logic                                          clk_i,
    input  wire logic                                          resetn_i,
    input  wire logic [7:0]                                    reg_addr_i,
    input  wire logic [7:0]                                    reg_wdata_i,
    input  wire logic                                          reg_wr_i,
    input  wire logic                                          reg_rd_i,
    output logic      [7:0]                                    reg_rdata_o,
    output logic                                               p3_half_duplex_o,
    output logic                                               p3_pause_en_o,
    output logic                                               p3_speed_10_o,
    output logic                                               p3_mac_role_o,
    input  wire logic                                          port4_tx_ref_clock_i,
    input  wire logic [1:0]                                    p4_tx_data_i,
    output logic      [1:0]                                    p4_txd_o,
    output logic                                               port4_rx_ref_clock_o,
    input  wire logic                                          sched_req_i,
    input  wire logic [mrpc_pkg::NUM_QUEUES-1:0]               q_pending_i,
    input  wire logic                                          top_rate_ok_i,
    input  wire logic [3*mrpc_pkg::WEIGHT_W-1:0]               low_weight_i,
    output logic      [mrpc_pkg::NUM_QUEUES-1:0]               q_grant_o
);
    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    logic [2:0] link_ctrl;
    logic       role_mac;
    logic       tx_inv;
    logic       rx_inv;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            link_ctrl <= mrpc_pkg::RST_P3_LINK_CTRL[7:5];
            role_mac  <= mrpc_pkg::RST_P3_ROLE_SEL[mrpc_pkg::BIT_MAC_ROLE];
            tx_inv    <= mrpc_pkg::RST_CLK_PHASE[mrpc_pkg::BIT_TX_INVERT];
            rx_inv    <= mrpc_pkg::RST_CLK_PHASE[mrpc_pkg::BIT_RX_INVERT];
        end else if (reg_wr_i) begin
            // Only documented control bits take writes; reserved bits stay fixed [RULE_09]
            case (reg_addr_i)
                mrpc_pkg::ADDR_P3_LINK_CTRL: begin
                    link_ctrl <= reg_wdata_i[7:5];
                end
                mrpc_pkg::ADDR_P3_ROLE_SEL: begin
                    role_mac <= reg_wdata_i[mrpc_pkg::BIT_MAC_ROLE];
                end
                mrpc_pkg::ADDR_CLK_PHASE: begin
                    tx_inv <= reg_wdata_i[mrpc_pkg::BIT_TX_INVERT];
                    rx_inv <= reg_wdata_i[mrpc_pkg::BIT_RX_INVERT];
                end
                default: begin
                end
            endcase
        end
    end

    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = mrpc_pkg::RD_UNMAPPED;
        case (reg_addr_i)
            mrpc_pkg::ADDR_P3_LINK_CTRL: begin
                next_rdata = {link_ctrl, 5'h00};
            end
            mrpc_pkg::ADDR_P3_ROLE_SEL: begin
                next_rdata = mrpc_pkg::FIX_ROLE_RSVD;                                 // [RULE_09]
                next_rdata[mrpc_pkg::BIT_MAC_ROLE] = role_mac;
            end
            mrpc_pkg::ADDR_TEST_THREE: begin
                next_rdata = mrpc_pkg::FIX_TEST_THREE;                                // [RULE_09]
            end
            mrpc_pkg::ADDR_CLK_PHASE: begin
                next_rdata = 8'h00;
                next_rdata[mrpc_pkg::BIT_TX_INVERT] = tx_inv;
                next_rdata[mrpc_pkg::BIT_RX_INVERT] = rx_inv;
            end
            default: begin
                next_rdata = mrpc_pkg::RD_UNMAPPED;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // Port 3 link mode
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            p3_half_duplex_o <= 1'b0;
            p3_pause_en_o    <= 1'b0;
            p3_speed_10_o    <= 1'b0;
            p3_mac_role_o    <= 1'b0;
        end else begin
            p3_half_duplex_o <= link_ctrl[2];                                         // [RULE_01]
            // Pause frames only mean anything on a full-duplex link
            p3_pause_en_o    <= link_ctrl[1] & ~link_ctrl[2];                         // [RULE_02]
            p3_speed_10_o    <= link_ctrl[0];                                         // [RULE_03]
            p3_mac_role_o    <= role_mac;                                             // [RULE_04]
        end
    end

    // ----------------------------------------------------------------
    // Port 4 reference clock phase
    // ----------------------------------------------------------------
    logic ref_s1;
    logic ref_s2;
    logic ref_s3;
    logic ref_edge;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ref_s1 <= 1'b0;
            ref_s2 <= 1'b0;
            ref_s3 <= 1'b0;
        end else begin
            ref_s1 <= port4_tx_ref_clock_i;
            ref_s2 <= ref_s1;
            ref_s3 <= ref_s2;
        end
    end

    // Rising edge normally, falling edge when inverted
    assign ref_edge = (ref_s2 ^ tx_inv) & ~(ref_s3 ^ tx_inv);                         // [RULE_05]

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            p4_txd_o <= 2'h0;
        end else if (ref_edge) begin
            p4_txd_o <= p4_tx_data_i;                                                 // [RULE_05]
        end
    end

    // Forwarded copy of the reference; lags the pin by three clocks (ref_s1, ref_s2, then this output register)
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            port4_rx_ref_clock_o <= 1'b0;
        end else begin
            port4_rx_ref_clock_o <= ref_s2 ^ rx_inv;                                  // [RULE_06]
        end
    end

    // ----------------------------------------------------------------
    // Egress queue scheduler
    // ----------------------------------------------------------------
    logic [1:0]                   low_ptr;
    logic [mrpc_pkg::WEIGHT_W-1:0] low_cnt;
    logic [mrpc_pkg::WEIGHT_W-1:0] cur_weight;
    logic                          top_go;
    logic                          low_go;
    logic [1:0]                    next_ptr;

    assign cur_weight = low_weight_i[low_ptr*mrpc_pkg::WEIGHT_W +: mrpc_pkg::WEIGHT_W];
    assign top_go     = q_pending_i[mrpc_pkg::TOP_QUEUE] & top_rate_ok_i;            // [RULE_08]
    assign low_go     = q_pending_i[low_ptr] & (low_cnt < cur_weight);
    assign next_ptr   = (low_ptr == mrpc_pkg::LOW_LAST) ? 2'h0 : 2'(low_ptr + 2'h1);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q_grant_o <= '0;
            low_ptr   <= 2'h0;
            low_cnt   <= '0;
        end else begin
            q_grant_o <= '0;
            if (sched_req_i) begin
                if (top_go) begin
                    q_grant_o[mrpc_pkg::TOP_QUEUE] <= 1'b1;                           // [RULE_08]
                end else if (low_go) begin
                    // Weighted share among the lower queues
                    q_grant_o[low_ptr] <= 1'b1;                                       // [RULE_08]
                    low_cnt            <= mrpc_pkg::WEIGHT_W'(low_cnt + 1'b1);
                end else begin
                    low_ptr <= next_ptr;
                    low_cnt <= '0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_half_duplex;
        @(posedge clk_i) disable iff (!resetn_i)
        (reg_wr_i && reg_addr_i == mrpc_pkg::ADDR_P3_LINK_CTRL) |-> ##2 p3_half_duplex_o == $past(reg_wdata_i[7], 2);
    endproperty
    a_half_duplex: assert property (p_half_duplex) else $error("duplex output does not follow write"); // [RULE_01]

    property p_pause;
        @(posedge clk_i) disable iff (!resetn_i)
        p3_pause_en_o |-> !p3_half_duplex_o;
    endproperty
    a_pause: assert property (p_pause) else $error("pause enabled on half duplex link"); // [RULE_02]

    property p_speed;
        @(posedge clk_i) disable iff (!resetn_i)
        (reg_wr_i && reg_addr_i == mrpc_pkg::ADDR_P3_LINK_CTRL) |-> ##2 p3_speed_10_o == $past(reg_wdata_i[5], 2);
    endproperty
    a_speed: assert property (p_speed) else $error("speed output does not follow write"); // [RULE_03]

    property p_role;
        @(posedge clk_i) disable iff (!resetn_i)
        (reg_wr_i && reg_addr_i == mrpc_pkg::ADDR_P3_ROLE_SEL) |-> ##2 p3_mac_role_o == $past(reg_wdata_i[6], 2);
    endproperty
    a_role: assert property (p_role) else $error("role output does not follow write"); // [RULE_04]

    property p_tx_edge;
        @(posedge clk_i) disable iff (!resetn_i)
        $changed(p4_txd_o) |-> ($past(ref_s2) ^ $past(tx_inv)) && !($past(ref_s3) ^ $past(tx_inv))
                               && (p4_txd_o == $past(p4_tx_data_i));
    endproperty
    a_tx_edge: assert property (p_tx_edge) else $error("transmit data changed off the active edge"); // [RULE_05]

    property p_rx_phase;
        @(posedge clk_i) disable iff (!resetn_i)
        ##1 port4_rx_ref_clock_o == ($past(ref_s2) ^ $past(rx_inv));
    endproperty
    a_rx_phase: assert property (p_rx_phase) else $error("receive reference phase wrong"); // [RULE_06]

    property p_top_first;
        @(posedge clk_i) disable iff (!resetn_i)
        (sched_req_i && q_pending_i[3] && top_rate_ok_i) |=> q_grant_o == 4'h8;
    endproperty
    a_top_first: assert property (p_top_first) else $error("top queue not granted first"); // [RULE_08]

    property p_top_limit;
        @(posedge clk_i) disable iff (!resetn_i)
        q_grant_o[3] |-> $past(top_rate_ok_i) && $past(sched_req_i);
    endproperty
    a_top_limit: assert property (p_top_limit) else $error("top queue granted beyond its rate"); // [RULE_08]

    property p_reserved;
        @(posedge clk_i) disable iff (!resetn_i)
        (reg_rd_i && reg_addr_i == mrpc_pkg::ADDR_TEST_THREE) |=> reg_rdata_o == 8'h32;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved register value changed"); // [RULE_09]

    property p_role_rsvd;
        @(posedge clk_i) disable iff (!resetn_i)
        (reg_rd_i && reg_addr_i == mrpc_pkg::ADDR_P3_ROLE_SEL) |=> reg_rdata_o[5:0] == 6'h2C;
    endproperty
    a_role_rsvd: assert property (p_role_rsvd) else $error("role register reserved bits altered"); // [RULE_09]
endmodule

// >>> test/mrpc_link_partner.sv
// Far-side reference clock source for the port 4 reduced link
`timescale 1ns/10ps
module mrpc_link_partner #(
    parameter real HALF_NS = 32.0
) (
    output logic ref_clk_o
);
    // ----------------------------------------------------------------
    // Reference oscillator
    // ----------------------------------------------------------------
    // Runs free like a real oscillator; offset keeps it off the system clock phase
    initial begin
        ref_clk_o = 1'b0;
        #3.3;
        forever #(HALF_NS) ref_clk_o = ~ref_clk_o;
    end
endmodule

// >>> test/mrpc_port_config_tb_top.sv
// Self-checking bench for the port configuration block
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module mrpc_port_config_tb_top;
    logic        clk_i    = 1'b0;
    logic        resetn_i = 1'b0;
    logic [7:0]  addr     = 8'h00;
    logic [7:0]  wdata    = 8'h00;
    logic        wr       = 1'b0;
    logic        rd       = 1'b0;
    logic        req      = 1'b0;
    logic        top_ok   = 1'b0;
    logic [1:0]  txd_in   = 2'h0;
    logic [3:0]  pend     = 4'h0;
    logic [11:0] wgt      = 12'h102;
    logic [15:0] lf       = 16'h870D;
    logic [1:0]  ptr      = 2'h0;
    logic [3:0]  cnt      = 4'h0;
    logic [7:0]  rdata, d, r;
    logic [1:0]  txd, old;
    logic [3:0]  grant, g;
    logic        half, pause, spd, role, ref_clk, rx_clk;
    int          mismatches = 0;
    int          checks     = 0;
    int          cycles     = 0;

    always #4 clk_i = ~clk_i;

    mrpc_link_partner partner (.ref_clk_o(ref_clk));

    mrpc_port_config dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .p3_half_duplex_o(half),
        .p3_pause_en_o(pause), .p3_speed_10_o(spd), .p3_mac_role_o(role),
        .port4_tx_ref_clock_i(ref_clk), .p4_tx_data_i(txd_in), .p4_txd_o(txd),
        .port4_rx_ref_clock_o(rx_clk), .sched_req_i(req), .q_pending_i(pend),
        .top_rate_ok_i(top_ok), .low_weight_i(wgt), .q_grant_o(grant)
    );

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] rnd();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf[7:0];
    endfunction

    // Pointer only moves on a refused request
    function automatic logic [3:0] exp_grant(logic [3:0] p, logic ok);
        if (ok && p[3]) return 4'h8;
        if (p[ptr] && cnt < wgt[ptr*4 +: 4]) begin
            cnt++;
            return 4'h1 << ptr;
        end
        ptr = (ptr == 2'h2) ? 2'h0 : ptr + 2'h1;
        cnt = 4'h0;
        return 4'h0;
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_i);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            end_sim();
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk_i);
        resetn_i <= 1'b1;
        rdchk(8'hCF, 8'h00);
        rdchk(8'hDF, 8'h2C);
        rdchk(8'hEF, 8'h32);
        rdchk(8'hFF, 8'h00);
        `CHK({half, pause, spd, role}, 4'h0)
        for (int i = 0; i < 12; i++) begin
            d = (i == 0) ? 8'hFF : (i == 1) ? 8'h40 : rnd();
            wr_reg(8'hCF, d);
            rdchk(8'hCF, d & 8'hE0);
            `CHK({half, pause, spd}, {d[7], d[6] & ~d[7], d[5]})
            wr_reg(8'hDF, d);
            rdchk(8'hDF, 8'h2C | (d & 8'h40));
            `CHK(role, d[6])
            wr_reg(8'hEF, d);
            rdchk(8'hEF, 8'h32);
            rdchk(8'h5A, 8'h00);
        end
        // Every combination of the two phase controls, reserved bits set too
        for (int m = 0; m < 4; m++) begin
            d = {1'b1, m[1], 1'b1, m[0], 4'hF};
            wr_reg(8'hFF, d);
            rdchk(8'hFF, d & 8'h50);
            @(posedge ref_clk);
            @(posedge clk_i);
            old = txd;
            txd_in <= ~txd;
            cyc(5);
            `CHK(rx_clk, ~m[0])
            `CHK(txd, m[1] ? old : ~old)
            @(negedge ref_clk);
            cyc(6);
            `CHK(rx_clk, m[0])
            `CHK(txd, ~old)
        end
        // Four-queue mode assumed set up before any per-queue limiting
        for (int i = 0; i < 80; i++) begin
            r = (i < 4) ? 8'h38 : rnd();
            @(posedge clk_i);
            if (i == 40)
                wgt <= 12'h302;
            req    <= 1'b1;
            pend   <= r[3:0];
            top_ok <= r[4] | r[5];
            @(posedge clk_i);
            req <= 1'b0;
            #1;
            g = exp_grant(r[3:0], r[4] | r[5]);
            `CHK(grant, g)
        end
        end_sim();
    end
endmodule
